/* File: rtks_pin_model.sv */
`timescale 1ns/100ps
module rtks_pin_model #(
    parameter int W = 4
) (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [W-1:0] oe_n,
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] pu_en,
    // Key contacts, high = closed to ground
    input wire logic [W-1:0] press,
    // Resolved pin level
    output logic [W-1:0] pin
);
    logic [W-1:0] float_q = '0;

    // Unpulled, undriven pins wander so a stale level never reads as valid
    always_ff @(posedge clk) begin
        float_q <= ~pin;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n[i]) begin
                pin[i] = drv[i];
            end else if (press[i]) begin
                pin[i] = 1'b0;
            end else if (pu_en[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule : rtks_pin_model

/* File: rtks_pkg.sv */
package rtks_pkg;

    // ************************************************
    // Port widths
    // ************************************************
    localparam int KEY_W = 4;
    localparam int STB_W = 3;
    localparam int AUX_W = 4;
    localparam int PLS_W = 2;
    localparam int SYNC_W = KEY_W + STB_W + AUX_W + PLS_W;

    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [7:0] OFS_KEY_DATA = 8'h00;
    localparam logic [7:0] OFS_KEY_SET = 8'h04;
    localparam logic [7:0] OFS_KEY_CLR = 8'h08;
    localparam logic [7:0] OFS_STB_DATA = 8'h0C;
    localparam logic [7:0] OFS_STB_SET = 8'h10;
    localparam logic [7:0] OFS_STB_CLR = 8'h14;
    localparam logic [7:0] OFS_AUX_DATA = 8'h18;
    localparam logic [7:0] OFS_AUX_SET = 8'h1C;
    localparam logic [7:0] OFS_AUX_CLR = 8'h20;
    localparam logic [7:0] OFS_AUX_PULLUP = 8'h24;
    localparam logic [7:0] OFS_PLS_DATA = 8'h28;
    localparam logic [7:0] OFS_CTRL = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CTRL_SCAN_BIT = 0;
    localparam int CTRL_IR_EN_BIT = 1;
    localparam int CTRL_HALT_BIT = 2;
    localparam int STAT_HALT_BIT = 0;
    localparam int STAT_WAKE_BIT = 1;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [KEY_W-1:0] RST_KEY = 4'hF;
    localparam logic [STB_W-1:0] RST_STB = 3'h7;
    localparam logic [AUX_W-1:0] RST_AUX = 4'hF;
    localparam logic [AUX_W-1:0] RST_AUX_PU = 4'hF;
    localparam logic [PLS_W-1:0] RST_PLS = 2'h3;
    localparam logic RST_SCAN = 1'b1;
    localparam logic RST_IR_EN = 1'b0;

    // ************************************************
    // Power state
    // ************************************************
    typedef enum logic [1:0] {
        PWR_RUN = 2'b01,
        PWR_HALT = 2'b10
    } rtks_pwr_e;

endpackage : rtks_pkg

/* File: rtks_ports.sv */
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
// What this block does
// R1 - Key and strobe pins are inputs with latch high, driven outputs latch low.
// R2 - A key press on an input-mode key or strobe pin wakes from halt.
// R3 - Each key, strobe and aux bit can be set or cleared alone via set/clear writes.
// R4 - Port read gives pin level for input bits, latch for output bits.
// R5 - Auxiliary bit is input only with latch high and pull-up enabled.
// R6 - Auxiliary pull-ups are switched on and off by software.
// R7 - After reset pulled-up ports come up as inputs with pull-ups on.
// R8 - In halt key pins strobe in strobe-scan, keep levels in hold-scan.
// R9 - In halt strobe pins strobe in strobe-scan, drive low in hold-scan.
// R10 - Without strobe-scan the affected pins are forced low throughout halt.
// R11 - IR carrier open drain is switched off in reset and halt.
// R12 - Pulse pins are open drain and float in reset and halt.
// R13 - A port write changes the latch and pin direction on that cycle.
module rtks_ports
    import rtks_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Key input port
    input wire logic [KEY_W-1:0] KEY_IN,
    output logic [KEY_W-1:0] KEY_OUT,
    output logic [KEY_W-1:0] KEY_OE_N,
    output logic [KEY_W-1:0] KEY_PU_EN,
    // Strobe port
    input wire logic [STB_W-1:0] STB_IN,
    output logic [STB_W-1:0] STB_OUT,
    output logic [STB_W-1:0] STB_OE_N,
    output logic [STB_W-1:0] STB_PU_EN,
    // Auxiliary port
    input wire logic [AUX_W-1:0] AUX_IN,
    output logic [AUX_W-1:0] AUX_OUT,
    output logic [AUX_W-1:0] AUX_OE_N,
    output logic [AUX_W-1:0] AUX_PU_EN,
    // Pulse port, open drain
    input wire logic [PLS_W-1:0] PLS_IN,
    output logic [PLS_W-1:0] PLS_OUT,
    output logic [PLS_W-1:0] PLS_OE_N,
    // IR carrier output, open drain
    input wire logic CARRIER_IN,
    output logic IR_OUT,
    output logic IR_OE_N,
    // Power state
    output logic HALTED,
    output logic WAKE
);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [KEY_W-1:0] key_s;
    logic [STB_W-1:0] stb_s;
    logic [AUX_W-1:0] aux_s;
    logic [PLS_W-1:0] pls_s;

    assign pins_raw = {PLS_IN, AUX_IN, STB_IN, KEY_IN};

    rtks_sync2 #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(RESET),
        .d_in(pins_raw),
        .d_out(pins_s)
    );

    assign key_s = pins_s[KEY_W-1:0];
    assign stb_s = pins_s[KEY_W+STB_W-1:KEY_W];
    assign aux_s = pins_s[KEY_W+STB_W+AUX_W-1:KEY_W+STB_W];
    assign pls_s = pins_s[SYNC_W-1:KEY_W+STB_W+AUX_W];

    // ************************************************
    // Bus decode
    // ************************************************
    logic ack_q;
    logic req;
    logic wr;
    logic [7:0] ofs;
    logic [31:0] wdat;

    assign req = WB_CYC_I & WB_STB_I;
    // Write lands on the edge where the master sees ack
    assign wr = req & WB_WE_I & ack_q & WB_SEL_I[0];
    assign ofs = {WB_ADR_I[7:2], 2'b00};
    assign wdat = WB_DAT_I;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ************************************************
    // Output latches
    // ************************************************
    logic [KEY_W-1:0] key_q, key_d;
    logic [STB_W-1:0] stb_q, stb_d;
    logic [AUX_W-1:0] aux_q, aux_d;
    logic [AUX_W-1:0] aux_pu_q, aux_pu_d;
    logic [PLS_W-1:0] pls_q, pls_d;
    logic scan_q;
    logic ir_en_q;

    always_comb begin
        key_d = key_q;
        stb_d = stb_q;
        aux_d = aux_q;
        aux_pu_d = aux_pu_q;
        pls_d = pls_q;
        if (wr) begin
            case (ofs)
                OFS_KEY_DATA: key_d = wdat[KEY_W-1:0];
                OFS_KEY_SET: key_d = key_q | wdat[KEY_W-1:0]; // R3
                OFS_KEY_CLR: key_d = key_q & ~wdat[KEY_W-1:0]; // R3
                OFS_STB_DATA: stb_d = wdat[STB_W-1:0];
                OFS_STB_SET: stb_d = stb_q | wdat[STB_W-1:0]; // R3
                OFS_STB_CLR: stb_d = stb_q & ~wdat[STB_W-1:0]; // R3
                OFS_AUX_DATA: aux_d = wdat[AUX_W-1:0];
                OFS_AUX_SET: aux_d = aux_q | wdat[AUX_W-1:0]; // R3
                OFS_AUX_CLR: aux_d = aux_q & ~wdat[AUX_W-1:0]; // R3
                OFS_AUX_PULLUP: aux_pu_d = wdat[AUX_W-1:0]; // R6
                OFS_PLS_DATA: pls_d = wdat[PLS_W-1:0];
                default: key_d = key_q;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            key_q <= RST_KEY; // R7
            stb_q <= RST_STB; // R7
            aux_q <= RST_AUX; // R7
            aux_pu_q <= RST_AUX_PU; // R7
            pls_q <= RST_PLS;
        end else begin
            key_q <= key_d; // R13
            stb_q <= stb_d; // R13
            aux_q <= aux_d; // R13
            aux_pu_q <= aux_pu_d;
            pls_q <= pls_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            scan_q <= RST_SCAN;
            ir_en_q <= RST_IR_EN;
        end else if (wr && ofs == OFS_CTRL) begin
            scan_q <= wdat[CTRL_SCAN_BIT];
            ir_en_q <= wdat[CTRL_IR_EN_BIT];
        end
    end

    // ************************************************
    // Halt and wake
    // ************************************************
    rtks_pwr_e pwr_q;
    logic halt_req;
    logic press;
    logic wake_q;
    logic wake_clr;

    assign halt_req = wr && ofs == OFS_CTRL && wdat[CTRL_HALT_BIT];
    assign wake_clr = wr && ofs == OFS_STATUS && wdat[STAT_WAKE_BIT];
    // Only input-mode pins sense keys; hold-scan strobes are driven
    assign press = |(key_q & ~key_s)
        | (scan_q & |(stb_q & ~stb_s)); // R2

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pwr_q <= PWR_RUN;
        end else begin
            case (pwr_q)
                PWR_RUN: if (halt_req) begin
                    pwr_q <= PWR_HALT;
                end
                PWR_HALT: if (press) begin
                    pwr_q <= PWR_RUN; // R2
                end
                default: pwr_q <= PWR_RUN;
            endcase
        end
    end

    // Sticky wake flag; a new wake beats a clear
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wake_q <= 1'b0;
        end else if (pwr_q == PWR_HALT && press) begin
            wake_q <= 1'b1; // R2
        end else if (wake_clr) begin
            wake_q <= 1'b0;
        end
    end

    logic halt_d, scan_d;
    assign halt_d = pwr_q == PWR_HALT ? !press : halt_req;
    assign scan_d = wr && ofs == OFS_CTRL ? wdat[CTRL_SCAN_BIT] : scan_q;

    // ************************************************
    // Pin drivers
    // ************************************************
    logic [KEY_W-1:0] key_oe_d;
    logic [STB_W-1:0] stb_oe_d;
    logic [AUX_W-1:0] aux_oe_d, aux_out_d;
    logic [AUX_W-1:0] aux_in_mode;

    // Key pins keep latch-driven levels in both halt modes
    genvar gi;
    generate
        for (gi = 0; gi < KEY_W; gi++) begin : g_key
            assign key_oe_d[gi] = key_d[gi]; // R1 R8
        end
        for (gi = 0; gi < STB_W; gi++) begin : g_stb
            assign stb_oe_d[gi] = stb_d[gi] & ~(halt_d & ~scan_d); // R1 R9 R10
        end
        for (gi = 0; gi < AUX_W; gi++) begin : g_aux
            assign aux_in_mode[gi] = aux_q[gi] & aux_pu_q[gi]; // R5
            assign aux_oe_d[gi] = aux_d[gi] & aux_pu_d[gi]
                & ~(halt_d & ~scan_d); // R5 R10
            assign aux_out_d[gi] = aux_d[gi] & ~(halt_d & ~scan_d); // R10
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            KEY_OE_N <= '1;
            KEY_OUT <= '0;
            KEY_PU_EN <= '1;
            STB_OE_N <= '1;
            STB_OUT <= '0;
            STB_PU_EN <= '1;
            AUX_OE_N <= '1;
            AUX_OUT <= '0;
            AUX_PU_EN <= '1;
        end else begin
            KEY_OE_N <= key_oe_d; // R1 R13
            KEY_OUT <= '0;
            KEY_PU_EN <= key_oe_d;
            STB_OE_N <= stb_oe_d; // R1 R13
            STB_OUT <= '0;
            STB_PU_EN <= stb_oe_d;
            AUX_OE_N <= aux_oe_d; // R5
            AUX_OUT <= aux_out_d;
            AUX_PU_EN <= aux_pu_d & aux_d; // R6
        end
    end

    // Open drain: latch low pulls low, released in reset and halt
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PLS_OE_N <= '1; // R12
            PLS_OUT <= '0;
            IR_OE_N <= 1'b1; // R11
            IR_OUT <= 1'b0;
        end else begin
            PLS_OE_N <= pls_d | {PLS_W{halt_d}}; // R12
            PLS_OUT <= '0;
            IR_OE_N <= ~(ir_en_q & CARRIER_IN & ~halt_d); // R11
            IR_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            HALTED <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            HALTED <= halt_d;
            WAKE <= pwr_q == PWR_HALT && press;
        end
    end

    // ************************************************
    // Read data
    // ************************************************
    logic [31:0] rdat;

    always_comb begin
        rdat = 32'h0000_0000;
        case (ofs)
            OFS_KEY_DATA: rdat[KEY_W-1:0] = key_q & key_s; // R4
            OFS_STB_DATA: rdat[STB_W-1:0] = stb_q & stb_s; // R4
            OFS_AUX_DATA: rdat[AUX_W-1:0] =
                (aux_in_mode & aux_s) | (~aux_in_mode & aux_q); // R4
            OFS_AUX_PULLUP: rdat[AUX_W-1:0] = aux_pu_q;
            OFS_PLS_DATA: rdat[PLS_W-1:0] = pls_s;
            OFS_CTRL: begin
                rdat[CTRL_SCAN_BIT] = scan_q;
                rdat[CTRL_IR_EN_BIT] = ir_en_q;
            end
            OFS_STATUS: begin
                rdat[STAT_HALT_BIT] = pwr_q == PWR_HALT;
                rdat[STAT_WAKE_BIT] = wake_q;
            end
            default: rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req & ~ack_q;
            WB_DAT_O <= (req & ~ack_q) ? rdat : 32'h0000_0000;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    a_key_dir_follow: assert property ( // R1
        KEY_OE_N == key_q
    ) else $error("key direction differs from latch");

    a_key_set_bit: assert property ( // R3
        (wr && ofs == OFS_KEY_SET) |=>
            key_q == ($past(key_q) | $past(wdat[KEY_W-1:0]))
    ) else $error("key set disturbed other bits");

    a_stb_clr_bit: assert property ( // R3
        (wr && ofs == OFS_STB_CLR) |=>
            stb_q == ($past(stb_q) & ~$past(wdat[STB_W-1:0]))
    ) else $error("strobe clear disturbed other bits");

    a_wake_on_press: assert property ( // R2
        (pwr_q == PWR_HALT && press) |=> pwr_q == PWR_RUN && wake_q && WAKE
    ) else $error("key press did not wake");

    a_aux_input_mode: assert property ( // R5
        (!HALTED && AUX_OE_N != '0) |-> (AUX_OE_N & ~(aux_q & aux_pu_q)) == '0
    ) else $error("aux input without latch and pull-up");

    a_hold_strobe_low: assert property ( // R9
        (HALTED && !scan_q) |-> !(|{STB_OE_N, AUX_OE_N, AUX_OUT})
    ) else $error("hold-scan halt pins not low");

    a_ir_off_halt: assert property ( // R11
        HALTED |-> IR_OE_N && PLS_OE_N == '1
    ) else $error("open drain active during halt");

    a_reset_inputs: assert property ( // R7
        $fell(RESET) |-> KEY_OE_N == '1 && STB_OE_N == '1 && KEY_PU_EN == '1
    ) else $error("ports not inputs after reset");

    a_key_read_mix: assert property ( // R4
        (req && !WB_WE_I && !ack_q && ofs == OFS_KEY_DATA) |=>
            WB_ACK_O && WB_DAT_O[KEY_W-1:0] == ($past(key_q) & $past(key_s))
    ) else $error("key read data wrong");

endmodule : rtks_ports

/* File: rtks_ports_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
n_errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module rtks_ports_tb_top;
    import rtks_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, carrier = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, ir_out, ir_oe_n, halted, wake;
    logic [KEY_W-1:0] key_in, key_out, key_oe_n, key_pu, key_prs = '0;
    logic [STB_W-1:0] stb_in, stb_out, stb_oe_n, stb_pu;
    logic [AUX_W-1:0] aux_in, aux_out, aux_oe_n, aux_pu, aux_prs = '0;
    logic [PLS_W-1:0] pls_in, pls_out, pls_oe_n;
    int n_errors = 0;
    int n_compared = 0;

    rtks_ports i_rtks_ports (.CLK_SYS(clk_sys), .RESET(reset),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .KEY_IN(key_in), .KEY_OUT(key_out), .KEY_OE_N(key_oe_n),
        .KEY_PU_EN(key_pu), .STB_IN(stb_in), .STB_OUT(stb_out),
        .STB_OE_N(stb_oe_n), .STB_PU_EN(stb_pu), .AUX_IN(aux_in),
        .AUX_OUT(aux_out), .AUX_OE_N(aux_oe_n), .AUX_PU_EN(aux_pu),
        .PLS_IN(pls_in), .PLS_OUT(pls_out), .PLS_OE_N(pls_oe_n),
        .CARRIER_IN(carrier), .IR_OUT(ir_out), .IR_OE_N(ir_oe_n),
        .HALTED(halted), .WAKE(wake));
    rtks_pin_model #(.W(KEY_W)) i_key_pins (.clk(clk_sys), .oe_n(key_oe_n),
        .drv(key_out), .pu_en(key_pu), .press(key_prs), .pin(key_in));
    rtks_pin_model #(.W(STB_W)) i_stb_pins (.clk(clk_sys), .oe_n(stb_oe_n),
        .drv(stb_out), .pu_en(stb_pu), .press('0), .pin(stb_in));
    rtks_pin_model #(.W(AUX_W)) i_aux_pins (.clk(clk_sys), .oe_n(aux_oe_n),
        .drv(aux_out), .pu_en(aux_pu), .press(aux_prs), .pin(aux_in));
    // Pulse loads hang from the supply, so released pins read high
    rtks_pin_model #(.W(PLS_W)) i_pls_pins (.clk(clk_sys), .oe_n(pls_oe_n),
        .drv(pls_out), .pu_en('1), .press('0), .pin(pls_in));

    // ************************************************
    // Clock, watchdog, verdict
    // ************************************************
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200us;
        n_errors++;
        results();
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // ************************************************
    // Bus access
    // ************************************************
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1);
        `CHK("bus ack", 1'b1, ack)
        `CHK("bus ack wait", 2, n)
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, ex, rdat)
    endtask : rd

    // Checks after a step see what the previous edges launched
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : step

    // Wake must follow within the synchroniser delay plus margin
    task automatic wait_wake();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wake !== 1'b1 && n < 10);
        `CHK("wake pulse", 1'b1, wake)
        step(1);
        `CHK("halted after wake", 1'b0, halted)
    endtask : wait_wake

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        step(3);
        `CHK("key oe in reset", 4'hF, key_oe_n)
        `CHK("ir oe in reset", 1'b1, ir_oe_n)
        `CHK("pulse oe in reset", 2'h3, pls_oe_n)
        step(3);
        reset <= 1'b0;
        step(2);
        `CHK("key pull-up", 4'hF, key_pu)
        `CHK("strobe oe", 3'h7, stb_oe_n)
        `CHK("aux oe", 4'hF, aux_oe_n)
        rd("aux pull-up reg", OFS_AUX_PULLUP, 32'hF);
        rd("unmapped", 8'hFC, 32'h0);
        // Per-bit set and clear, one to four bits per write
        wr(OFS_KEY_CLR, 32'h2);
        step(1);
        `CHK("key clr one", 4'hD, key_oe_n)
        wr(OFS_KEY_SET, 32'h2);
        wr(OFS_KEY_CLR, 32'h9);
        step(1);
        `CHK("key oe pattern", 4'h6, key_oe_n)
        wr(OFS_STB_CLR, 32'h4);
        wr(OFS_STB_CLR, 32'h1);
        wr(OFS_STB_SET, 32'h4);
        step(1);
        `CHK("strobe oe", 3'h6, stb_oe_n)
        key_prs <= 4'h2;
        step(3);
        rd("key read", OFS_KEY_DATA, 32'h4);
        key_prs <= 4'h0;
        wr(OFS_KEY_SET, 32'hF);
        wr(OFS_STB_SET, 32'h7);
        // Pull-up off turns a latched-high aux bit into a driver
        wr(OFS_AUX_PULLUP, 32'hB);
        wr(OFS_AUX_CLR, 32'h1);
        step(1);
        `CHK("aux oe", 4'hA, aux_oe_n)
        `CHK("aux pull-up", 4'hA, aux_pu)
        aux_prs <= 4'h2;
        step(3);
        rd("aux read", OFS_AUX_DATA, 32'hC);
        aux_prs <= 4'h0;
        wr(OFS_AUX_PULLUP, 32'hF);
        wr(OFS_AUX_SET, 32'hF);
        // Whole-port data writes
        wr(OFS_KEY_DATA, 32'hA);
        wr(OFS_STB_DATA, 32'h5);
        wr(OFS_AUX_DATA, 32'h5);
        step(1);
        `CHK("key data write", 4'hA, key_oe_n)
        `CHK("aux data write", 4'h5, aux_oe_n)
        rd("strobe read", OFS_STB_DATA, 32'h5);
        wr(OFS_KEY_DATA, 32'hF);
        wr(OFS_STB_DATA, 32'h7);
        wr(OFS_AUX_DATA, 32'hF);
        // Carrier and pulse while running
        carrier <= 1'b1;
        wr(OFS_CTRL, 32'h3);
        wr(OFS_PLS_DATA, 32'h2);
        step(2);
        `CHK("ir sinking", 1'b0, ir_oe_n)
        `CHK("pulse pulling", 2'h2, pls_oe_n)
        rd("pulse read", OFS_PLS_DATA, 32'h2);
        rd("ctrl read", OFS_CTRL, 32'h3);
        // Strobe-scan halt: latch-low key pin keeps strobing
        wr(OFS_KEY_CLR, 32'h1);
        wr(OFS_CTRL, 32'h7);
        step(1);
        `CHK("halted", 1'b1, halted)
        step(2);
        `CHK("key strobe", 4'hE, key_oe_n)
        `CHK("strobe pins", 3'h7, stb_oe_n)
        `CHK("ir off in halt", 1'b1, ir_oe_n)
        `CHK("pulse float", 2'h3, pls_oe_n)
        key_prs <= 4'h4;
        wait_wake();
        key_prs <= 4'h0;
        rd("status wake", OFS_STATUS, 32'h2);
        wr(OFS_STATUS, 32'h2);
        rd("status cleared", OFS_STATUS, 32'h0);
        // Hold-scan halt: strobe and aux forced low, key keeps levels
        wr(OFS_CTRL, 32'h4);
        step(2);
        `CHK("key kept", 4'hE, key_oe_n)
        `CHK("strobe low", 3'h0, stb_oe_n)
        `CHK("strobe level", 3'h0, stb_in)
        `CHK("aux low", 4'h0, aux_oe_n)
        `CHK("aux out low", 4'h0, aux_out)
        `CHK("drive levels", 10'h0, {key_out, stb_out, pls_out, ir_out})
        `CHK("pulse float hold", 2'h3, pls_oe_n)
        key_prs <= 4'h8;
        wait_wake();
        key_prs <= 4'h0;
        step(2);
        `CHK("strobe restored", 3'h7, stb_oe_n)
        results();
    end
endmodule : rtks_ports_tb_top

/* File: rtks_sync2.sv */
`timescale 1ns/100ps
module rtks_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] d_out
);

    // ************************************************
    // Two-stage synchroniser, first stage read only here
    // ************************************************
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '1;
            d_out <= '1;
        end else begin
            meta_q <= d_in;
            d_out <= meta_q;
        end
    end

endmodule : rtks_sync2
